/* File: rtl/memory_map_pkg.sv */
// package for the memory map decoder: widths, sizes and request carriers
package memory_map_pkg;
   localparam int PRG_AW        = 24;
   localparam int INT_PRG_AW    = 16;
   localparam int DIRECT_AW     = 8;
   localparam int USER_SFR_AW   = 7;
   localparam int DATA_W        = 8;
   localparam logic [16:0] ROM_SIZE_DEFAULT = 17'h08000;
   localparam logic [16:0] RAM_SIZE_DEFAULT = 17'h04000;
   localparam logic [16:0] SPACE_64K        = 17'h10000;
   localparam logic [7:0]  SFR_BASE         = 8'h80;
   localparam int          USER_SFR_MAX     = 104;
   localparam logic [7:0]  DPX_RESET        = 8'h00;

   typedef enum logic [1:0] {
      TGT_NONE,
      TGT_IROM,
      TGT_IRAM,
      TGT_EXT
   } prg_target_t;

   typedef struct packed {
      logic                  rd;
      logic                  wr;
      logic [PRG_AW-1:0]     addr;
      logic [DATA_W-1:0]     wdata;
   } prg_req_t;

   typedef struct packed {
      logic                  rd;
      logic                  wr;
      logic                  dpx_wr;
      logic [15:0]           addr;
      logic [DATA_W-1:0]     wdata;
   } xdata_req_t;

   typedef struct packed {
      logic                  rd;
      logic                  wr;
      logic                  is_sfr;
      logic [DIRECT_AW-1:0]  addr;
      logic [DATA_W-1:0]     wdata;
   } direct_req_t;
endpackage

/* File: rtl/prg_region_decode.sv */
// program address region decoder
`timescale 1ns/1ps
`default_nettype none
module prg_region_decode
   import memory_map_pkg::*;
(
   input  wire logic [PRG_AW-1:0] addr,
   input  wire logic [16:0]       rom_size,
   input  wire logic [16:0]       ram_size,
   output prg_target_t            target
);
   logic [16:0] ram_base;
   logic        in_low64k;

   assign ram_base  = SPACE_64K - ram_size;
   assign in_low64k = (addr[PRG_AW-1:16] == 8'h00);

   always_comb begin
      target = TGT_EXT;
      if (in_low64k && ({1'b0, addr[15:0]} < rom_size)) begin
         target = TGT_IROM;
      end else if (in_low64k && (ram_size != 17'h00000) &&
                   ({1'b0, addr[15:0]} >= ram_base)) begin
         target = TGT_IRAM;
      end
   end
endmodule
`default_nettype wire

/* File: rtl/memory_map_decoder.sv */
// memory map decoder: program, data and user register routing with wait hold
`timescale 1ns/1ps
`default_nettype none
module memory_map_decoder
   import memory_map_pkg::*;
#(
   parameter logic [16:0]  ROM_SIZE   = ROM_SIZE_DEFAULT,
   parameter logic [16:0]  RAM_SIZE   = RAM_SIZE_DEFAULT,
   parameter logic [127:0] CORE_SFR_MAP = 128'h0
)
(
   input  wire logic                   REF_CLK,
   input  wire logic                   RST_N,
   input  wire prg_req_t               PRG_REQ,
   input  wire xdata_req_t             XDATA_REQ,
   input  wire direct_req_t            DIRECT_REQ,
   input  wire logic [DATA_W-1:0]      PRG_ROM_RDATA,
   input  wire logic [DATA_W-1:0]      PRG_RAM_RDATA,
   input  wire logic [DATA_W-1:0]      XDATA_RDATA,
   input  wire logic [DATA_W-1:0]      RAM_RDATA,
   input  wire logic [DATA_W-1:0]      USER_SFR_RDATA,
   input  wire logic                   READY,
   output logic [INT_PRG_AW-1:0]       PRG_ADDR,
   output logic [DATA_W-1:0]           PRG_WDATA,
   output logic                        PRG_ROM_RD,
   output logic                        PRG_RAM_RD,
   output logic                        PRG_RAM_WR,
   output logic [PRG_AW-1:0]           XADDR,
   output logic [DATA_W-1:0]           XDATA_WDATA,
   output logic                        XPRG_RD,
   output logic                        XPRG_WR,
   output logic                        XRAM_RD,
   output logic                        XRAM_WR,
   output logic [DIRECT_AW-1:0]        RAM_ADDR,
   output logic [DATA_W-1:0]           RAM_WDATA,
   output logic                        RAM_OE,
   output logic                        RAM_WE,
   output logic [USER_SFR_AW-1:0]      USER_SFR_ADDR,
   output logic [DATA_W-1:0]           USER_SFR_WDATA,
   output logic                        USER_SFR_OE,
   output logic                        USER_SFR_WE,
   output logic [DATA_W-1:0]           PRG_RDATA,
   output logic [DATA_W-1:0]           XDATA_OUT,
   output logic [DATA_W-1:0]           DIRECT_RDATA,
   output logic [7:0]                  DATA_POINTER_EXTENSION,
   output logic                        CORE_HOLD
);
   prg_target_t        target;
   logic               ready_m_r;
   logic               ready_s_r;
   logic               ext_busy;
   logic [1:0]         ext_run_r;
   logic [1:0]         ext_run_nxt;
   logic               ready_ok;
   logic [7:0]         dpx_r;
   logic [7:0]         dpx_nxt;
   logic [DATA_W-1:0]  prg_rdata_r;
   logic [DATA_W-1:0]  prg_rdata_nxt;
   logic [DATA_W-1:0]  xdata_r;
   logic [DATA_W-1:0]  xdata_nxt;
   logic [DATA_W-1:0]  direct_r;
   logic [DATA_W-1:0]  direct_nxt;
   logic               user_hit;

   // core register map bit set means the core owns that address
   function automatic logic core_owns(input logic [DIRECT_AW-1:0] a);
      return CORE_SFR_MAP[a[6:0]];
   endfunction

   prg_region_decode u_decode (
      .addr     (PRG_REQ.addr),
      .rom_size (ROM_SIZE),
      .ram_size (RAM_SIZE),
      .target   (target)
   );

   // ready synchroniser, ready comes from off-chip memory
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ready_m_r <= 1'b0;
         ready_s_r <= 1'b0;
      end else begin
         ready_m_r <= READY;
         ready_s_r <= ready_m_r;
      end
   end

   assign ext_busy  = (target == TGT_EXT && (PRG_REQ.rd || PRG_REQ.wr)) ||
                      XDATA_REQ.rd || XDATA_REQ.wr;

   // synced ready is two edges old; only trust it once the access has lasted that long,
   // so a ready left over from the previous access cannot release the next one if ext_busy drops for a cycle between them
   always_comb begin
      ext_run_nxt = {ext_run_r[0], ext_busy};
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ext_run_r <= 2'h0;
      end else begin
         ext_run_r <= ext_run_nxt;
      end
   end
   assign ready_ok  = ready_s_r && (ext_run_r == 2'h3);
   assign CORE_HOLD = ext_busy && !ready_ok;

   always_comb begin
      PRG_ROM_RD = PRG_REQ.rd && (target == TGT_IROM);
      PRG_RAM_RD = PRG_REQ.rd && (target == TGT_IRAM);
      // rom cannot be written; such writes are dropped
      PRG_RAM_WR = PRG_REQ.wr && (target == TGT_IRAM);
      XPRG_RD    = PRG_REQ.rd && (target == TGT_EXT);
      XPRG_WR    = PRG_REQ.wr && (target == TGT_EXT);
   end

   assign PRG_ADDR  = PRG_REQ.addr[INT_PRG_AW-1:0];
   assign PRG_WDATA = PRG_REQ.wdata;

   always_comb begin
      dpx_nxt = dpx_r;
      if (XDATA_REQ.dpx_wr) begin
         dpx_nxt = XDATA_REQ.wdata;
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         dpx_r <= DPX_RESET;
      end else begin
         dpx_r <= dpx_nxt;
      end
   end
   assign DATA_POINTER_EXTENSION = dpx_r;

   always_comb begin
      if (XPRG_RD || XPRG_WR) begin
         XADDR = PRG_REQ.addr;
      end else begin
         XADDR = {dpx_r, XDATA_REQ.addr};
      end
      XDATA_WDATA = (XPRG_WR) ? PRG_REQ.wdata : XDATA_REQ.wdata;
      // data access waits behind a program access on the shared bus
      XRAM_RD = XDATA_REQ.rd && !(XPRG_RD || XPRG_WR);
      XRAM_WR = XDATA_REQ.wr && !(XPRG_RD || XPRG_WR);
   end

   // only where core leaves a gap
   assign user_hit = DIRECT_REQ.is_sfr && (DIRECT_REQ.addr >= SFR_BASE) &&
                     !core_owns(DIRECT_REQ.addr);

   // single port ram, one ram strobe per cycle
   always_comb begin
      RAM_ADDR       = DIRECT_REQ.addr;
      RAM_WDATA      = DIRECT_REQ.wdata;
      RAM_OE         = DIRECT_REQ.rd && !DIRECT_REQ.is_sfr;
      RAM_WE         = DIRECT_REQ.wr && !DIRECT_REQ.is_sfr && !RAM_OE;
      USER_SFR_ADDR  = DIRECT_REQ.addr[USER_SFR_AW-1:0];
      USER_SFR_WDATA = DIRECT_REQ.wdata;
      USER_SFR_OE    = DIRECT_REQ.rd && user_hit;
      USER_SFR_WE    = DIRECT_REQ.wr && user_hit;
   end

   // read data is sampled from the memory in the strobe cycle (external reads once ready_ok) and shows after that edge
   always_comb begin
      prg_rdata_nxt = prg_rdata_r;
      xdata_nxt     = xdata_r;
      direct_nxt    = direct_r;
      if (PRG_ROM_RD) begin
         prg_rdata_nxt = PRG_ROM_RDATA;
      end else if (PRG_RAM_RD) begin
         prg_rdata_nxt = PRG_RAM_RDATA;
      end else if (XPRG_RD && ready_ok) begin
         prg_rdata_nxt = XDATA_RDATA;
      end
      if (XRAM_RD && ready_ok) begin
         xdata_nxt = XDATA_RDATA;
      end
      if (USER_SFR_OE) begin
         direct_nxt = USER_SFR_RDATA;
      end else if (RAM_OE) begin
         direct_nxt = RAM_RDATA;
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         prg_rdata_r <= 8'h00;
         xdata_r     <= 8'h00;
         direct_r    <= 8'h00;
      end else begin
         prg_rdata_r <= prg_rdata_nxt;
         xdata_r     <= xdata_nxt;
         direct_r    <= direct_nxt;
      end
   end
   assign PRG_RDATA    = prg_rdata_r;
   assign XDATA_OUT    = xdata_r;
   assign DIRECT_RDATA = direct_r;
endmodule
`default_nettype wire

/* File: tb/memory_map_assertions.sv */
// port assertions for the memory map decoder
`timescale 1ns/1ps
`default_nettype none
module memory_map_assertions
   import memory_map_pkg::*;
#(
   parameter logic [16:0]  ROM_SIZE     = ROM_SIZE_DEFAULT,
   parameter logic [16:0]  RAM_SIZE     = RAM_SIZE_DEFAULT,
   parameter logic [127:0] CORE_SFR_MAP = 128'h0
)
(
   input wire logic        REF_CLK,
   input wire logic        RST_N,
   input wire prg_req_t    PRG_REQ,
   input wire xdata_req_t  XDATA_REQ,
   input wire direct_req_t DIRECT_REQ,
   input wire logic        READY,
   input wire logic [15:0] PRG_ADDR,
   input wire logic        PRG_ROM_RD,
   input wire logic        PRG_RAM_RD,
   input wire logic        PRG_RAM_WR,
   input wire logic        XPRG_RD,
   input wire logic        XPRG_WR,
   input wire logic        XRAM_RD,
   input wire logic        XRAM_WR,
   input wire logic [23:0] XADDR,
   input wire logic        RAM_OE,
   input wire logic        USER_SFR_OE,
   input wire logic [6:0]  USER_SFR_ADDR,
   input wire logic [7:0]  DATA_POINTER_EXTENSION,
   input wire logic        CORE_HOLD
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   wire logic ext = XPRG_RD || XPRG_WR || XRAM_RD || XRAM_WR;
   wire logic [23:0] pa = PRG_REQ.addr;
   wire logic [7:0]  da = DIRECT_REQ.addr;
   wire logic free = DIRECT_REQ.is_sfr && da[7] && !CORE_SFR_MAP[da[6:0]];
   // ready reaches the hold two edges late through its synchroniser
   sequence lo_s; !READY ##2 ext; endsequence
   sequence hi_s; READY ##1 ext ##1 ext; endsequence
   AST_ROM: assert property (PRG_REQ.rd && pa < ROM_SIZE |-> PRG_ROM_RD && !XPRG_RD)
      else $error("rom fetch not routed to rom");
   AST_RAM: assert property (PRG_REQ.rd && pa >= ROM_SIZE && pa < SPACE_64K
      && pa >= SPACE_64K - RAM_SIZE |-> PRG_RAM_RD) else $error("ram window fetch missed");
   AST_EXT: assert property (PRG_REQ.rd && pa >= SPACE_64K |-> XPRG_RD && XADDR == pa)
      else $error("high fetch not external");
   AST_ONE: assert property ($onehot0({PRG_ROM_RD, PRG_RAM_RD, PRG_RAM_WR, XPRG_RD, XPRG_WR}))
      else $error("more than one program strobe");
   AST_PADDR: assert property (PRG_ADDR == pa[15:0])
      else $error("internal program address wrong");
   AST_DPX: assert property (XDATA_REQ.dpx_wr |=> DATA_POINTER_EXTENSION == $past(XDATA_REQ.wdata))
      else $error("extension register not loaded");
   AST_XDA: assert property (XRAM_RD |-> XADDR == {DATA_POINTER_EXTENSION, XDATA_REQ.addr})
      else $error("data address lacks segment");
   AST_SFR: assert property (DIRECT_REQ.rd && free |-> USER_SFR_OE && USER_SFR_ADDR == da[6:0])
      else $error("user register read missed");
   AST_SFR_OWN: assert property (USER_SFR_OE |-> free)
      else $error("user register strobe on taken address");
   AST_IRAM: assert property (DIRECT_REQ.rd && !DIRECT_REQ.is_sfr |-> RAM_OE && !USER_SFR_OE)
      else $error("internal ram read missed");
   AST_HOLD: assert property (lo_s |-> CORE_HOLD)
      else $error("core not held while memory waits");
   AST_GO: assert property (hi_s |-> !CORE_HOLD)
      else $error("core held after ready");
endmodule
bind memory_map_decoder memory_map_assertions #(.ROM_SIZE(ROM_SIZE), .RAM_SIZE(RAM_SIZE),
   .CORE_SFR_MAP(CORE_SFR_MAP)) i_memory_map_assertions (.*);
`default_nettype wire

/* File: tb/mem_partner.sv */
// behavioural memories and user registers on the decoder's far side
`timescale 1ns/1ps
`default_nettype none
module mem_partner
(
   input  wire logic        REF_CLK,
   input  wire logic [2:0]  LAG,
   input  wire logic [15:0] PRG_ADDR,
   input  wire logic [23:0] XADDR,
   input  wire logic [7:0]  RAM_ADDR,
   input  wire logic [6:0]  USER_SFR_ADDR,
   input  wire logic        PRG_ROM_RD,
   input  wire logic        PRG_RAM_RD,
   input  wire logic        XPRG_RD,
   input  wire logic        XPRG_WR,
   input  wire logic        XRAM_RD,
   input  wire logic        XRAM_WR,
   input  wire logic        RAM_OE,
   input  wire logic        USER_SFR_OE,
   output logic [7:0]       PRG_ROM_RDATA,
   output logic [7:0]       PRG_RAM_RDATA,
   output logic [7:0]       XDATA_RDATA,
   output logic [7:0]       RAM_RDATA,
   output logic [7:0]       USER_SFR_RDATA,
   output logic             READY
);
   logic       ext;
   logic [2:0] cnt_r;
   assign ext = XPRG_RD | XPRG_WR | XRAM_RD | XRAM_WR;
   always_ff @(posedge REF_CLK) cnt_r <= !ext ? 3'h0 : cnt_r + 3'(cnt_r != LAG);
   assign READY = ext && cnt_r == LAG;
   // unselected data lines show the inverse, so stale values never match
   assign PRG_ROM_RDATA = PRG_ADDR[7:0] ^ 8'h11 ^ {8{!PRG_ROM_RD}};
   assign PRG_RAM_RDATA = PRG_ADDR[7:0] ^ 8'h22 ^ {8{!PRG_RAM_RD}};
   assign XDATA_RDATA = XADDR[7:0] ^ 8'h33 ^ {8{!READY}};
   assign RAM_RDATA = RAM_ADDR ^ 8'h44 ^ {8{!RAM_OE}};
   assign USER_SFR_RDATA = {1'b1, USER_SFR_ADDR} ^ 8'h55 ^ {8{!USER_SFR_OE}};
endmodule
`default_nettype wire

/* File: tb/memory_map_decoder_tb.sv */
// self-checking bench for the memory map decoder
`timescale 1ns/1ps
`default_nettype none
module memory_map_decoder_tb;
   import memory_map_pkg::*;
   localparam logic [127:0] MAP = 128'h1;
   logic REF_CLK = 1'b0;
   logic RST_N = 1'b0;
   prg_req_t PRG_REQ;
   xdata_req_t XDATA_REQ;
   direct_req_t DIRECT_REQ;
   logic [2:0] LAG;
   logic [23:0] XADDR;
   logic [15:0] PRG_ADDR;
   logic [7:0] PRG_ROM_RDATA, PRG_RAM_RDATA, XDATA_RDATA, RAM_RDATA, USER_SFR_RDATA;
   logic [7:0] PRG_WDATA, XDATA_WDATA, RAM_ADDR, RAM_WDATA, USER_SFR_WDATA;
   logic [7:0] PRG_RDATA, XDATA_OUT, DIRECT_RDATA, DATA_POINTER_EXTENSION;
   logic [6:0] USER_SFR_ADDR;
   logic READY, PRG_ROM_RD, PRG_RAM_RD, PRG_RAM_WR, XPRG_RD, XPRG_WR, XRAM_RD, XRAM_WR;
   logic RAM_OE, RAM_WE, USER_SFR_OE, USER_SFR_WE, CORE_HOLD;
   int fails = 0, total_checks = 0, n, i, seed;
   logic [31:0] r;
   memory_map_decoder #(.CORE_SFR_MAP(MAP)) i_memory_map_decoder (.*);
   mem_partner i_mem_partner (.*);
   always #25 REF_CLK = ~REF_CLK;
   function automatic logic [7:0] ev(logic [7:0] k, logic [7:0] a);
      return a ^ (k * 8'h11);
   endfunction
   function automatic logic [2:0] tgt(logic [23:0] a);
      if (a < 24'(ROM_SIZE_DEFAULT)) return 3'b001;
      if (a < 24'(SPACE_64K) && a >= 24'(SPACE_64K - RAM_SIZE_DEFAULT)) return 3'b010;
      return 3'b100;
   endfunction
   task automatic test_done();
      if (fails == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(string nm, logic [23:0] e, logic [23:0] s);
      total_checks++;
      if (e !== s) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask
   // bounded wait for the hold to drop, then past the capture edge
   task automatic hold_wait();
      n = 0;
      while (CORE_HOLD !== 1'b0 && n < 40) begin
         @(negedge REF_CLK);
         n++;
      end
      if (n == 40) begin
         fails++;
         test_done();
      end
      @(negedge REF_CLK);
   endtask
   task automatic prg(logic [23:0] a, logic w);
      logic [2:0] t;
      t = tgt(a);
      PRG_REQ = '{!w, w, a, 8'hA5};
      #1;
      if (!w) chk("prg_target", t, {XPRG_RD, PRG_RAM_RD, PRG_ROM_RD});
      else chk("prg_write", t[2:1], {XPRG_WR, PRG_RAM_WR});
      hold_wait();
      if (!w) chk("prg_rdata", ev(t[0] ? 1 : t[1] ? 2 : 3, a[7:0]), PRG_RDATA);
      PRG_REQ = '0;
      @(negedge REF_CLK);
   endtask
   task automatic xd(logic [7:0] x, logic [15:0] a);
      XDATA_REQ = '{1'b0, 1'b0, 1'b1, 16'h0000, x};
      @(negedge REF_CLK);
      XDATA_REQ = '{1'b1, 1'b0, 1'b0, a, 8'h00};
      #1;
      chk("xaddr", {x, a}, XADDR);
      hold_wait();
      chk("xdata", ev(3, a[7:0]), XDATA_OUT);
      XDATA_REQ = '0;
      @(negedge REF_CLK);
   endtask
   task automatic dr(logic s, logic [7:0] a);
      logic u;
      u = s && a[7] && !MAP[a[6:0]];
      DIRECT_REQ = '{1'b1, 1'b0, s, a, 8'h00};
      #1;
      chk("sfr_oe", u, USER_SFR_OE);
      chk("ram_oe", !s, RAM_OE);
      @(negedge REF_CLK);
      if (u || !s) chk("direct", ev(s ? 5 : 4, a), DIRECT_RDATA);
      DIRECT_REQ = '0;
      @(negedge REF_CLK);
   endtask
   initial begin
      seed = 32'h23894588;
      PRG_REQ = '0;
      XDATA_REQ = '0;
      DIRECT_REQ = '0;
      LAG = 3'h0;
      repeat (10) @(negedge REF_CLK);
      RST_N = 1'b1;
      for (i = 0; i < 8; i++) prg(i[0] ? 24'h00FFFF : 24'h007FFC + 24'(i), i[1]);
      prg(24'h000000, 1'b0);
      prg(24'h007FFF, 1'b0);
      prg(24'h008000, 1'b0);
      prg(24'h00C000, 1'b0);
      prg(24'hFFFFFF, 1'b0);
      prg(24'h000010, 1'b1);
      dr(1'b1, 8'h80);
      dr(1'b1, 8'h7F);
      dr(1'b1, 8'hFF);
      dr(1'b0, 8'hFF);
      repeat (60) begin
         r = $random(seed);
         LAG = r[30:28];
         prg(r[27] ? {8'h00, r[15:0]} : r[23:0], r[26]);
         xd(r[7:0], r[23:8]);
         dr(r[25], r[15:8]);
      end
      test_done();
   end
endmodule
`default_nettype wire
